/* core/pmawm_top.sv */
// Activity monitor that reloads the idle timer and raises wake-up strobes
// Function
// - Enabled IRQ7..3,1 wakes in reduced power
// - Enabled IRQ in normal mode only reloads
// - Wake-up reloads timer and strobes power port
// - High enables map IRQ15,14,12..8
// - Enabled DRQ wakes in reduced power
// - Enabled DRQ in normal mode only reloads
// - Programmable range access wakes when enabled
// - Programmable range access in normal reloads
// - Area accesses wake in reduced power
// - Area accesses in normal mode only reload
// - Video memory, video ports, disk ports decoded
// - Floppy port 3F5, keyboard 60/64 decoded
// - Local device claim wakes or reloads
// - Master request wakes only with wake enable
// - Duration code selects 15s to 240min
// - Wake enable bit allows master wake
`timescale 1ns/10ps
module pmawm_top
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reduced_power_mode,
  input wire logic [15:0] irq_pin,
  input wire logic [7:0] drq_pin,
  input wire logic local_device_claim_n,
  input wire logic local_master_request_n,
  input wire pmawm_pkg::pmawm_bus_t bus_i,
  output logic global_idle_timer_reload,
  output logic power_port_strobe_n,
  output logic [15:0] global_idle_timer_sec
);
  localparam int NPIN = 26;

  // Reset release through two flops
  logic rst_s1_reg;
  logic rst_int_n;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_int_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_int_n <= rst_s1_reg;
    end
  end

  // Pin synchroniser; a level counts once stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;
  logic [NPIN-1:0] lvl_reg;
  logic [NPIN-1:0] lvl_next;
  logic [NPIN-1:0] rise;
  assign pin_raw = {~local_master_request_n, ~local_device_claim_n, drq_pin, irq_pin};
  assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
  assign rise = lvl_next & ~lvl_reg;
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end
    else
    begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  // Enable and control registers
  logic [7:0] irq_low_activity_enable_reg;
  logic [7:0] irq_high_activity_enable_reg;
  logic [7:0] dma_request_activity_enable_reg;
  logic [7:0] device_area_monitor_enable_reg;
  logic [2:0] timer_sel_reg;
  logic wake_local_master_request_en_reg;
  logic wake_flag_reg;

  // Bus decode
  logic [7:0] idx;
  logic req;
  logic wr;
  logic rd;
  logic wr_b0;
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign wr_b0 = wr & wb_sel_i[0];

  // Register writes take effect at the accepting edge
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      irq_low_activity_enable_reg <= pmawm_pkg::REG_RESET;
      irq_high_activity_enable_reg <= pmawm_pkg::REG_RESET;
      dma_request_activity_enable_reg <= pmawm_pkg::REG_RESET;
      device_area_monitor_enable_reg <= pmawm_pkg::REG_RESET;
      timer_sel_reg <= 3'h0;
      wake_local_master_request_en_reg <= 1'b0;
    end
    else if (wr_b0)
    begin
      // Reserved enable bits are stored but never steer logic; timer and wake keep only their used bits
      if (idx == pmawm_pkg::IDX_IRQ_LOW)
        irq_low_activity_enable_reg <= wb_dat_i[7:0];
      if (idx == pmawm_pkg::IDX_IRQ_HIGH)
        irq_high_activity_enable_reg <= wb_dat_i[7:0];
      if (idx == pmawm_pkg::IDX_DMA)
        dma_request_activity_enable_reg <= wb_dat_i[7:0];
      if (idx == pmawm_pkg::IDX_AREA)
        device_area_monitor_enable_reg <= wb_dat_i[7:0];
      if (idx == pmawm_pkg::IDX_TIMER_SEL)
        timer_sel_reg <= wb_dat_i[2:0];
      if (idx == pmawm_pkg::IDX_WAKE)
        wake_local_master_request_en_reg <= wb_dat_i[pmawm_pkg::WAKE_LOCAL_MASTER_REQUEST_EN];
    end
  end

  // Enabled IRQ activity; high map skips IRQ13
  logic [7:0] irq_lo_hit;
  logic [7:0] irq_hi_hit;
  logic [7:0] irq_hi_lines;
  logic irq_act;
  assign irq_lo_hit = rise[7:0] & irq_low_activity_enable_reg & pmawm_pkg::IRQ_LOW_USED;
  assign irq_hi_lines = {rise[15:14], 1'b0, rise[12:8]};
  assign irq_hi_hit = irq_hi_lines & irq_high_activity_enable_reg & pmawm_pkg::IRQ_HIGH_USED;
  assign irq_act = |irq_lo_hit | |irq_hi_hit;

  // Enabled DMA request activity; channel 4 is the cascade
  logic dma_act;
  assign dma_act = |(rise[23:16] & dma_request_activity_enable_reg & pmawm_pkg::DMA_USED);

  // Fixed area decoders
  logic hit_vmem;
  logic hit_vio;
  logic hit_hdd;
  logic hit_fdd;
  logic hit_kbd;
  logic [9:0] ioa;
  assign ioa = bus_i.io_addr;
  assign hit_vmem = bus_i.mem_access && bus_i.mem_addr[19:17] == pmawm_pkg::MEM_VIDEO_TOP;
  assign hit_vio = bus_i.io_access && ioa >= pmawm_pkg::IO_VID_LO && ioa <= pmawm_pkg::IO_VID_HI;
  assign hit_hdd = bus_i.io_access && (ioa[9:3] == pmawm_pkg::IO_HDD_BLK || ioa == pmawm_pkg::IO_HDD_CTL);
  assign hit_fdd = bus_i.io_access && ioa == pmawm_pkg::IO_FDD;
  assign hit_kbd = bus_i.io_access && (ioa == pmawm_pkg::IO_KBD_DATA || ioa == pmawm_pkg::IO_KBD_CMD);

  // Area and local bus activity under the monitor enables
  logic [7:0] area_raw;
  logic [7:0] area_hit;
  logic area_act;
  logic local_master_request_hit;
  assign area_raw = {bus_i.io_access & bus_i.range_hit, hit_vmem, hit_vio, hit_hdd, hit_fdd, hit_kbd,
                     rise[24], rise[25]};
  assign area_hit = area_raw & device_area_monitor_enable_reg;
  assign local_master_request_hit = area_hit[pmawm_pkg::AREA_LOCAL_MASTER_REQUEST];
  assign area_act = |area_hit;

  // Any activity reloads; master request wakes only with its enable
  logic any_act;
  logic wake_src;
  logic wake_ev;
  assign any_act = irq_act | dma_act | area_act;
  assign wake_src = irq_act | dma_act | |area_hit[7:1] | (local_master_request_hit & wake_local_master_request_en_reg);
  assign wake_ev = reduced_power_mode & wake_src;

  // One reload pulse per cycle of activity, one strobe per cycle of wake event
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      global_idle_timer_reload <= 1'b0;
      power_port_strobe_n <= 1'b1;
    end
    else
    begin
      global_idle_timer_reload <= any_act | wake_ev;
      power_port_strobe_n <= ~wake_ev;
    end
  end

  // Wake flag: hardware set beats the clear from a register access
  logic wake_acc;
  assign wake_acc = req & (idx == pmawm_pkg::IDX_WAKE);
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      wake_flag_reg <= 1'b0;
    else if (wake_ev)
      wake_flag_reg <= 1'b1;
    else if (wake_acc)
      wake_flag_reg <= 1'b0;
  end

  // Duration lookup for the idle timer
  logic [15:0] dur_next;
  always_comb
  begin
    case (timer_sel_reg)
      3'h0: dur_next = pmawm_pkg::DUR_SEC_0;
      3'h1: dur_next = pmawm_pkg::DUR_SEC_1;
      3'h2: dur_next = pmawm_pkg::DUR_SEC_2;
      3'h3: dur_next = pmawm_pkg::DUR_SEC_3;
      3'h4: dur_next = pmawm_pkg::DUR_SEC_4;
      3'h5: dur_next = pmawm_pkg::DUR_SEC_5;
      3'h6: dur_next = pmawm_pkg::DUR_SEC_6;
      default: dur_next = pmawm_pkg::DUR_SEC_7;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      global_idle_timer_sec <= pmawm_pkg::DUR_SEC_0;
    else
      global_idle_timer_sec <= dur_next;
  end

  // Read mux; unmapped indices read zero
  logic [7:0] rd_byte;
  assign rd_byte = (idx == pmawm_pkg::IDX_IRQ_LOW) ? irq_low_activity_enable_reg :
                   (idx == pmawm_pkg::IDX_IRQ_HIGH) ? irq_high_activity_enable_reg :
                   (idx == pmawm_pkg::IDX_DMA) ? dma_request_activity_enable_reg :
                   (idx == pmawm_pkg::IDX_AREA) ? device_area_monitor_enable_reg :
                   (idx == pmawm_pkg::IDX_TIMER_SEL) ? {5'h00, timer_sel_reg} :
                   (idx == pmawm_pkg::IDX_WAKE) ? {wake_flag_reg, 7'h00} : 8'h00;

  // Single wait state answer; ack drops the cycle after
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Checks
  sequence s_wake_out;
    global_idle_timer_reload && !power_port_strobe_n;
  endsequence
  sequence s_strobe_idle;
    power_port_strobe_n;
  endsequence
  sequence s_reload_only;
    global_idle_timer_reload && power_port_strobe_n;
  endsequence

  a_wake_strobe_reload: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    wake_ev |=> s_wake_out)
    else $error("wake event without reload and strobe");
  a_irq_low_wake: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (reduced_power_mode && rise[7] && irq_low_activity_enable_reg[7]) |=> s_wake_out)
    else $error("IRQ7 did not wake");
  a_normal_no_strobe: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (!reduced_power_mode && any_act) |=> (global_idle_timer_reload ##0 s_strobe_idle))
    else $error("normal mode activity strobed or missed reload");
  a_irq13_ignored: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (rise == 26'h0002000 && bus_i.io_access == 1'b0 && bus_i.mem_access == 1'b0) |=> !global_idle_timer_reload)
    else $error("IRQ13 caused activity");
  a_dma_wake: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (reduced_power_mode && rise[16] && dma_request_activity_enable_reg[0]) |=> s_wake_out)
    else $error("DRQ0 did not wake");
  a_local_master_request_gate: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (local_master_request_hit && !wake_local_master_request_en_reg && !irq_act && !dma_act && area_hit[7:1] == 7'h00) |=> s_strobe_idle)
    else $error("master request woke without enable");
  a_kbd_reload: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (bus_i.io_access && ioa == pmawm_pkg::IO_KBD_CMD && device_area_monitor_enable_reg[2]) |=> global_idle_timer_reload)
    else $error("keyboard access missed reload");
  a_strobe_single: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    $fell(power_port_strobe_n) |-> $past(wake_ev))
    else $error("strobe without wake event");
  a_duration_map: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (timer_sel_reg == 3'h7) |=> global_idle_timer_sec == 16'h3840)
    else $error("240 minute code wrong");
  a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (req && wb_cyc_i) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not single cycle");

  // Further sources in reduced power or normal mode, and sources that must stay silent
  a_irq_high_wake: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (reduced_power_mode && rise[15] && irq_high_activity_enable_reg[7]) |=> s_wake_out)
    else $error("IRQ15 did not wake");
  a_irq_normal: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (!reduced_power_mode && rise[3] && irq_low_activity_enable_reg[3]) |=> s_reload_only)
    else $error("normal mode IRQ did more than reload");
  a_irq0_ignored: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (rise == 26'h0000001 && !bus_i.io_access && !bus_i.mem_access) |=> !global_idle_timer_reload)
    else $error("IRQ0 caused activity");
  a_dma_normal_reload: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (!reduced_power_mode && rise[16] && dma_request_activity_enable_reg[0]) |=> s_reload_only)
    else $error("normal mode DRQ did more than reload");
  a_drq4_ignored: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (rise == 26'h0100000 && !bus_i.io_access && !bus_i.mem_access) |=> !global_idle_timer_reload)
    else $error("DRQ4 caused activity");
  a_range_wake: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (reduced_power_mode && bus_i.io_access && bus_i.range_hit && device_area_monitor_enable_reg[7])
      |=> s_wake_out)
    else $error("range access did not wake");
  a_range_normal: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (!reduced_power_mode && bus_i.io_access && bus_i.range_hit && device_area_monitor_enable_reg[7])
      |=> s_reload_only)
    else $error("normal mode range access did more than reload");
  a_vmem_wake: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (reduced_power_mode && bus_i.mem_access && bus_i.mem_addr[19:17] == pmawm_pkg::MEM_VIDEO_TOP
      && device_area_monitor_enable_reg[6]) |=> s_wake_out)
    else $error("video memory access did not wake");
  a_area_normal: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (!reduced_power_mode && bus_i.io_access && ioa == pmawm_pkg::IO_FDD && device_area_monitor_enable_reg[3])
      |=> s_reload_only)
    else $error("normal mode area access did more than reload");
  a_claim_wake: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (reduced_power_mode && rise[24] && device_area_monitor_enable_reg[1]) |=> s_wake_out)
    else $error("device claim did not wake");
  a_local_master_request_wake: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    (reduced_power_mode && rise[25] && device_area_monitor_enable_reg[0] && wake_local_master_request_en_reg) |=> s_wake_out)
    else $error("enabled master request did not wake");
  a_reload_quiet: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    !any_act |=> !global_idle_timer_reload)
    else $error("reload without activity");
endmodule

/* include/pmawm_pkg.sv */
// Constants and carrier types of the activity wake-up monitor
package pmawm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_SEL = 8'hE1;
  localparam logic [7:0] IDX_IRQ_LOW = 8'hE2;
  localparam logic [7:0] IDX_IRQ_HIGH = 8'hE3;
  localparam logic [7:0] IDX_DMA = 8'hE4;
  localparam logic [7:0] IDX_AREA = 8'hE5;
  localparam logic [7:0] IDX_WAKE = 8'hEE;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Used enable bits of the IRQ low, IRQ high and DMA enable registers
  localparam logic [7:0] IRQ_LOW_USED = 8'hFA;
  localparam logic [7:0] IRQ_HIGH_USED = 8'hDF;
  localparam logic [7:0] DMA_USED = 8'hEF;
  // Field positions
  localparam int AREA_RANGE = 7;
  localparam int AREA_VIDEO_MEM = 6;
  localparam int AREA_VIDEO_IO = 5;
  localparam int AREA_HDD = 4;
  localparam int AREA_FDD = 3;
  localparam int AREA_KBD = 2;
  localparam int AREA_LOCAL_DEVICE_CLAIM = 1;
  localparam int AREA_LOCAL_MASTER_REQUEST = 0;
  localparam int WAKE_LOCAL_MASTER_REQUEST_EN = 7;
  localparam int TIMER_SEL_W = 3;
  // Watched addresses
  localparam logic [2:0] MEM_VIDEO_TOP = 3'h5;
  localparam logic [9:0] IO_VID_LO = 10'h3B0;
  localparam logic [9:0] IO_VID_HI = 10'h3DF;
  localparam logic [6:0] IO_HDD_BLK = 7'h3E;
  localparam logic [9:0] IO_HDD_CTL = 10'h3F6;
  localparam logic [9:0] IO_FDD = 10'h3F5;
  localparam logic [9:0] IO_KBD_DATA = 10'h060;
  localparam logic [9:0] IO_KBD_CMD = 10'h064;
  // Idle timer durations in seconds
  localparam logic [15:0] DUR_SEC_0 = 16'h000F;
  localparam logic [15:0] DUR_SEC_1 = 16'h0078;
  localparam logic [15:0] DUR_SEC_2 = 16'h012C;
  localparam logic [15:0] DUR_SEC_3 = 16'h0384;
  localparam logic [15:0] DUR_SEC_4 = 16'h0708;
  localparam logic [15:0] DUR_SEC_5 = 16'h0A8C;
  localparam logic [15:0] DUR_SEC_6 = 16'h0E10;
  localparam logic [15:0] DUR_SEC_7 = 16'h3840;
  // Bus cycle seen by the monitor
  typedef struct packed {
    logic io_access;
    logic [9:0] io_addr;
    logic mem_access;
    logic [19:0] mem_addr;
    logic range_hit;
  } pmawm_bus_t;
endpackage

/* tb/pmawm_host_model.sv */
// Host activity source: ISA request pins, local bus pins and bus cycles
`timescale 1ns/10ps
module pmawm_host_model
(
  input wire logic ref_clk,
  output logic [15:0] irq_pin,
  output logic [7:0] drq_pin,
  output logic local_device_claim_n,
  output logic local_master_request_n,
  output pmawm_pkg::pmawm_bus_t bus_o
);
  // Everything idles inactive
  initial
  begin
    irq_pin = 16'h0000;
    drq_pin = 8'h00;
    local_device_claim_n = 1'b1;
    local_master_request_n = 1'b1;
    bus_o = '0;
  end
  // Held long enough to pass the three-flop filter, then released
  task automatic pin_pulse(input logic [15:0] irq, input logic [7:0] drq, input logic claim, input logic req);
    @(posedge ref_clk);
    irq_pin <= irq;
    drq_pin <= drq;
    local_device_claim_n <= ~claim;
    local_master_request_n <= ~req;
    repeat (6) @(posedge ref_clk);
    irq_pin <= 16'h0000;
    drq_pin <= 8'h00;
    local_device_claim_n <= 1'b1;
    local_master_request_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  // One-cycle access; afterwards the address shows its inverse, so a stale match cannot pass
  task automatic bus_cycle(input logic io, input logic [19:0] addr, input logic rng);
    @(posedge ref_clk);
    bus_o <= '{io, addr[9:0], ~io, addr, rng};
    @(posedge ref_clk);
    bus_o <= '{1'b0, ~addr[9:0], 1'b0, ~addr, 1'b0};
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

/* tb/pmawm_top_tb.sv */
// Self-checking bench for the activity wake-up monitor
`timescale 1ns/10ps
module pmawm_top_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [9:0] wb_adr = 10'h000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic reduced_power_mode = 1'b0;
  logic [15:0] irq;
  logic [7:0] drq;
  logic claim_n;
  logic req_n;
  pmawm_pkg::pmawm_bus_t bus;
  logic reload;
  logic strobe_n;
  logic [15:0] sec;
  logic [7:0] rd;
  logic [15:0] dur [8] = '{16'h000F, 16'h0078, 16'h012C, 16'h0384, 16'h0708, 16'h0A8C, 16'h0E10, 16'h3840};
  logic [7:0] used [4] = '{8'hFA, 8'hDF, 8'hEF, 8'hFF};
  int n_fail = 0;
  int tests_run = 0;
  int n_rel = 0;
  int n_stb = 0;
  int r0;
  int s0;
  pmawm_top i_pmawm_top (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .reduced_power_mode(reduced_power_mode), .irq_pin(irq), .drq_pin(drq),
    .local_device_claim_n(claim_n), .local_master_request_n(req_n), .bus_i(bus),
    .global_idle_timer_reload(reload), .power_port_strobe_n(strobe_n), .global_idle_timer_sec(sec));
  pmawm_host_model i_pmawm_host_model (.ref_clk(ref_clk), .irq_pin(irq), .drq_pin(drq),
    .local_device_claim_n(claim_n), .local_master_request_n(req_n), .bus_o(bus));
  always #20 ref_clk = ~ref_clk;
  // Pulses counted mid-cycle, away from the edge where the bench acts
  always @(negedge ref_clk)
  begin
    if (reload === 1'b1)
      n_rel++;
    if (strobe_n === 1'b0)
      n_stb++;
  end
  task automatic summarize;
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  // Compares reload and strobe pulses since the last mark
  task automatic chk_act(input int er, input int es);
    tests_run++;
    if (n_rel - r0 != er || n_stb - s0 != es)
    begin
      n_fail++;
      $display("unexpected at %0t: pulses %0d/%0d, wanted %0d/%0d", $time, n_rel - r0, n_stb - s0, er, es);
    end
    r0 = n_rel;
    s0 = n_stb;
  endtask
  // Classic cycle: request held until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= 4'h1;
    wb_wdat <= {24'h000000, wd};
    for (k = 0; k < 50 && wb_ack !== 1'b1; k++)
      @(posedge ref_clk);
    if (k == 50)
      chk_val(16'hDEAD, 16'h0000);
    rd = wb_rdat[7:0];
    chk_val(wb_rdat[31:16], 16'h0000);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  // Area access with a single enable; the opposite enables must stay silent
  task automatic area(input logic io, input logic [19:0] a, input logic rng, input int b, input logic hit);
    wb(1'b1, 8'hE5, 8'(1 << b));
    i_pmawm_host_model.bus_cycle(io, a, rng);
    chk_act(hit, hit & reduced_power_mode);
    wb(1'b1, 8'hE5, ~8'(1 << b));
    i_pmawm_host_model.bus_cycle(io, a, rng);
    chk_act(0, 0);
  endtask
  initial
  begin
    #1200000;
    n_fail++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    r0 = n_rel;
    s0 = n_stb;
    // Reset values, read-back, unmapped index answers zero
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b0, 8'hE2 + 8'(i), 8'h00);
      chk_val(rd, 8'h00);
      wb(1'b1, 8'hE2 + 8'(i), used[i]);
      wb(1'b0, 8'hE2 + 8'(i), 8'h00);
      chk_val(rd, used[i]);
    end
    wb(1'b1, 8'h40, 8'hFF);
    wb(1'b0, 8'h40, 8'h00);
    chk_val(rd, 8'h00);
    chk_val(sec, dur[0]);
    for (int c = 0; c < 8; c++)
    begin
      wb(1'b1, 8'hE1, 8'(c));
      repeat (2) @(posedge ref_clk);
      chk_val(sec, dur[c]);
    end
    for (int m = 0; m < 2; m++)
    begin
      @(posedge ref_clk);
      reduced_power_mode <= m[0];
      wb(1'b0, 8'hEE, 8'h00);
      r0 = n_rel;
      s0 = n_stb;
      for (int n = 0; n < 16; n++)
      begin
        i_pmawm_host_model.pin_pulse(16'(1 << n), 8'h00, 1'b0, 1'b0);
        chk_act(16'hDFFA >> n & 1, m & (16'hDFFA >> n & 1));
      end
      for (int n = 0; n < 8; n++)
      begin
        i_pmawm_host_model.pin_pulse(16'h0000, 8'(1 << n), 1'b0, 1'b0);
        chk_act(8'hEF >> n & 1, m & (8'hEF >> n & 1));
      end
      wb(1'b0, 8'hEE, 8'h00);
      chk_val(rd, {m[0], 7'h00});
      wb(1'b0, 8'hEE, 8'h00);
      chk_val(rd, 8'h00);
      area(1'b1, 20'h002A0, 1'b1, 7, 1'b1);
      area(1'b0, 20'hA0000, 1'b0, 6, 1'b1);
      area(1'b0, 20'hBFFFF, 1'b0, 6, 1'b1);
      area(1'b0, 20'hC0000, 1'b0, 6, 1'b0);
      area(1'b1, 20'h003B0, 1'b0, 5, 1'b1);
      area(1'b1, 20'h003DF, 1'b0, 5, 1'b1);
      area(1'b1, 20'h003AF, 1'b0, 5, 1'b0);
      area(1'b1, 20'h001F0, 1'b0, 4, 1'b1);
      area(1'b1, 20'h001F7, 1'b0, 4, 1'b1);
      area(1'b1, 20'h003F6, 1'b0, 4, 1'b1);
      area(1'b1, 20'h001F8, 1'b0, 4, 1'b0);
      area(1'b1, 20'h003F5, 1'b0, 3, 1'b1);
      area(1'b1, 20'h003F4, 1'b0, 3, 1'b0);
      area(1'b1, 20'h00060, 1'b0, 2, 1'b1);
      area(1'b1, 20'h00064, 1'b0, 2, 1'b1);
      area(1'b1, 20'h00061, 1'b0, 2, 1'b0);
      wb(1'b1, 8'hE5, 8'h03);
      i_pmawm_host_model.pin_pulse(16'h0000, 8'h00, 1'b1, 1'b0);
      chk_act(1, m);
      wb(1'b1, 8'hEE, 8'h00);
      i_pmawm_host_model.pin_pulse(16'h0000, 8'h00, 1'b0, 1'b1);
      chk_act(1, 0);
      wb(1'b1, 8'hEE, 8'h80);
      i_pmawm_host_model.pin_pulse(16'h0000, 8'h00, 1'b0, 1'b1);
      chk_act(1, m);
      // Simultaneous sources merge into one pulse
      i_pmawm_host_model.pin_pulse(16'h0088, 8'h01, 1'b1, 1'b1);
      chk_act(1, m);
    end
    summarize();
  end
endmodule
